// *** rtl/proximity_threshold_interrupt.v ***
// Summary of operation
// - result is 16 bits: high byte at 87h, low byte at 88h
// - result bytes are read-only; host writes leave them unchanged
// - 3-bit persistence: 1,2,4,8,16,32 for 000-101, 128 for 111
// - persistence resets to 000, one sample is enough
// - limit-interrupt enable at bit 1 flags above-high or below-low while select bit 0 is 0
// - low limit: high byte 8Ah, low byte 8Bh, read/write
// - high limit: high byte 8Ch, low byte 8Dh, read/write
// - status flags set on interrupt, cleared by writing one
// - active-low interrupt low while any status flag is set
// - result-valid flag set on new result, cleared by result read
`timescale 1ns/100ps
`default_nettype none
`include "prox_irq_map.vh"
module proximity_threshold_interrupt (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // register port from the i2c target
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // measurement engine
    input  wire       result_ready,
    input  wire [15:0] result_value,
    // interrupt pin
    output reg        int_n
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [15:0] result;
    reg [7:0]  int_control;
    reg [15:0] low_limit;
    reg [15:0] high_limit;
    reg        ready_flag;
    reg        below_limit_flag;
    reg        above_limit_flag;
    reg        result_valid;
    reg [7:0]  needed;
    reg [7:0]  next_rdata;
    reg        next_ready_flag;
    reg        next_below_limit_flag;
    reg        next_above_limit_flag;

    wire       sample;
    wire       hit_above;
    wire       hit_below;
    wire       wr_stat;
    wire       rd_result;
    wire       set_ready;
    wire       set_below;
    wire       set_above;
    wire       clr_ready;
    wire       clr_below;
    wire       clr_above;

    assign wr_stat   = reg_wr && (reg_addr == `ADDR_INT_STAT);
    assign rd_result = reg_rd && ((reg_addr == `ADDR_RES_HI) ||
                                  (reg_addr == `ADDR_RES_LO));
    // other sources are not modelled, so select 1 never compares
    assign sample    = result_ready && !int_control[`CTRL_LIM_SEL];

    assign set_ready = result_ready && int_control[`CTRL_RDY_EN];
    assign set_below = hit_below && int_control[`CTRL_LIM_EN];
    assign set_above = hit_above && int_control[`CTRL_LIM_EN];
    assign clr_ready = wr_stat && reg_wdata[`STAT_RDY];
    assign clr_below = wr_stat && reg_wdata[`STAT_BELOW];
    assign clr_above = wr_stat && reg_wdata[`STAT_ABOVE];

    // ------------------------------------------------------------
    // persistence decode
    // ------------------------------------------------------------
    always @* begin
        case (int_control[`CTRL_PERS_HI:`CTRL_PERS_LO])
            3'h0:    needed = `PERS_CNT_0;
            3'h1:    needed = `PERS_CNT_1;
            3'h2:    needed = `PERS_CNT_2;
            3'h3:    needed = `PERS_CNT_3;
            3'h4:    needed = `PERS_CNT_4;
            3'h5:    needed = `PERS_CNT_5;
            3'h6:    needed = `PERS_CNT_6;
            default: needed = `PERS_CNT_7;
        endcase
    end

    persist_counter above_count (
        .clk    (clk),
        .rst_n  (rst_n),
        .sample (sample),
        .beyond (result_value > high_limit),
        .needed (needed),
        .hit    (hit_above)
    );

    persist_counter below_count (
        .clk    (clk),
        .rst_n  (rst_n),
        .sample (sample),
        .beyond (result_value < low_limit),
        .needed (needed),
        .hit    (hit_below)
    );

    // ------------------------------------------------------------
    // register writes and result capture
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result      <= `RESULT_RESET;
            int_control <= `CTRL_RESET;
            low_limit   <= `LIMIT_RESET;
            high_limit  <= `LIMIT_RESET;
        end else begin
            if (result_ready) begin
                result <= result_value;
            end
            // result addresses are not decoded for writes
            if (reg_wr) begin
                case (reg_addr)
                    `ADDR_INT_CTRL: int_control <= reg_wdata & `CTRL_WMASK;
                    `ADDR_LOW_HI:   low_limit[15:8]  <= reg_wdata;
                    `ADDR_LOW_LO:   low_limit[7:0]   <= reg_wdata;
                    `ADDR_HIGH_HI:  high_limit[15:8] <= reg_wdata;
                    `ADDR_HIGH_LO:  high_limit[7:0]  <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // status flags: set wins over clear
    // ------------------------------------------------------------
    // a clear that meets a new event in the same cycle is dropped,
    // otherwise the host could lose an interrupt it never saw
    always @* begin
        next_ready_flag       = ready_flag;
        next_below_limit_flag = below_limit_flag;
        next_above_limit_flag = above_limit_flag;
        if (set_ready) begin
            next_ready_flag = 1'b1;
        end else if (clr_ready) begin
            next_ready_flag = 1'b0;
        end
        if (set_below) begin
            next_below_limit_flag = 1'b1;
        end else if (clr_below) begin
            next_below_limit_flag = 1'b0;
        end
        if (set_above) begin
            next_above_limit_flag = 1'b1;
        end else if (clr_above) begin
            next_above_limit_flag = 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_flag       <= 1'b0;
            below_limit_flag <= 1'b0;
            above_limit_flag <= 1'b0;
            result_valid     <= 1'b0;
        end else begin
            ready_flag       <= next_ready_flag;
            below_limit_flag <= next_below_limit_flag;
            above_limit_flag <= next_above_limit_flag;
            if (result_ready) begin
                result_valid <= 1'b1;
            end else if (rd_result) begin
                result_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------
    // fed from the next flag values so the pin falls with the flag,
    // not one cycle after it, and never glitches
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_n <= 1'b1;
        end else begin
            int_n <= !(next_ready_flag || next_below_limit_flag ||
                       next_above_limit_flag);
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `ADDR_CMD:      next_rdata[`CMD_VALID] = result_valid;
            `ADDR_RES_HI:   next_rdata = result[15:8];
            `ADDR_RES_LO:   next_rdata = result[7:0];
            `ADDR_INT_CTRL: next_rdata = int_control;
            `ADDR_LOW_HI:   next_rdata = low_limit[15:8];
            `ADDR_LOW_LO:   next_rdata = low_limit[7:0];
            `ADDR_HIGH_HI:  next_rdata = high_limit[15:8];
            `ADDR_HIGH_LO:  next_rdata = high_limit[7:0];
            `ADDR_INT_STAT: begin
                next_rdata[`STAT_RDY]   = ready_flag;
                next_rdata[`STAT_BELOW] = below_limit_flag;
                next_rdata[`STAT_ABOVE] = above_limit_flag;
            end
            default:        next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // proximity_threshold_interrupt
`default_nettype wire

// *** rtl/prox_irq_map.vh ***
`ifndef PROX_IRQ_MAP_VH
`define PROX_IRQ_MAP_VH
// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_CMD          8'h80
`define ADDR_RES_HI       8'h87
`define ADDR_RES_LO       8'h88
`define ADDR_INT_CTRL     8'h89
`define ADDR_LOW_HI       8'h8a
`define ADDR_LOW_LO       8'h8b
`define ADDR_HIGH_HI      8'h8c
`define ADDR_HIGH_LO      8'h8d
`define ADDR_INT_STAT     8'h8e
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define CTRL_PERS_HI      7
`define CTRL_PERS_LO      5
`define CTRL_RDY_EN       3
`define CTRL_LIM_EN       1
`define CTRL_LIM_SEL      0
`define CTRL_WMASK        8'heb
`define CTRL_RESET        8'h00
`define PERS_CNT_0        8'h01
`define PERS_CNT_1        8'h02
`define PERS_CNT_2        8'h04
`define PERS_CNT_3        8'h08
`define PERS_CNT_4        8'h10
`define PERS_CNT_5        8'h20
`define PERS_CNT_6        8'h40
`define PERS_CNT_7        8'h80
`define STAT_RDY          2
`define STAT_BELOW        1
`define STAT_ABOVE        0
`define CMD_VALID         5
`define LIMIT_RESET       16'h0000
`define RESULT_RESET      16'h0000
`endif

// *** rtl/persist_counter.v ***
`timescale 1ns/100ps
`default_nettype none
// counts consecutive out-of-limit samples for one direction
module persist_counter (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // sample stream
    input  wire       sample,
    input  wire       beyond,
    input  wire [7:0] needed,
    // result
    output reg        hit
);
    reg [7:0] count;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
            hit   <= 1'b0;
        end else begin
            hit <= 1'b0;
            if (sample) begin
                if (!beyond) begin
                    count <= 8'h00;
                end else if (count + 8'h01 >= needed) begin
                    hit   <= 1'b1;
                    // restart so the next interrupt needs a fresh run
                    count <= 8'h00;
                end else begin
                    count <= count + 8'h01;
                end
            end
        end
    end
endmodule // persist_counter
`default_nettype wire

// *** verification/prox_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// host side of the register port
// ------------------------------------
module prox_host (
    // register port
    input  wire logic       clk,
    output logic [7:0]      reg_addr = 8'h00,
    output logic            reg_wr = 1'b0,
    output logic [7:0]      reg_wdata = 8'h00,
    output logic            reg_rd = 1'b0,
    input  wire logic [7:0] reg_rdata
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // stale data must never be trusted
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule // prox_host
`default_nettype wire

// *** verification/prox_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// port checker
// ------------------------------------
module prox_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        result_ready,
    input wire logic [15:0] result_value,
    input wire logic        int_n
);
    logic [15:0] res, lo, hi;
    logic [7:0]  ctl;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow copies, rebuilt from port traffic only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {res, lo, hi, ctl} <= 56'h0;
        end else begin
            if (result_ready) res <= result_value;
            if (reg_wr && reg_addr == 8'h89) ctl <= reg_wdata & 8'heb;
            if (reg_wr && reg_addr == 8'h8a) lo[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == 8'h8b) lo[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == 8'h8c) hi[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == 8'h8d) hi[7:0] <= reg_wdata;
        end
    end
    property p_rh; reg_rd && reg_addr == 8'h87 |=> reg_rdata == $past(res[15:8]); endproperty
    a_rh: assert property (p_rh) else $error("result high read");
    property p_rl; reg_rd && reg_addr == 8'h88 |=> reg_rdata == $past(res[7:0]); endproperty
    a_rl: assert property (p_rl) else $error("result low read");
    property p_ctl; reg_rd && reg_addr == 8'h89 |=> reg_rdata == $past(ctl); endproperty
    a_ctl: assert property (p_ctl) else $error("control read");
    property p_low; reg_rd && reg_addr == 8'h8b |=> reg_rdata == $past(lo[7:0]); endproperty
    a_low: assert property (p_low) else $error("low limit read");
    property p_hil; reg_rd && reg_addr == 8'h8c |=> reg_rdata == $past(hi[15:8]); endproperty
    a_hil: assert property (p_hil) else $error("high limit read");
    property p_pin; reg_rd && reg_addr == 8'h8e |=> (|reg_rdata[2:0]) == !$past(int_n); endproperty
    a_pin: assert property (p_pin) else $error("pin vs status");
    property p_hold; !int_n && !reg_wr |=> !int_n; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_rdy; result_ready && ctl[3] |=> !int_n; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready irq");
    property p_lim;
        result_ready && ctl[7:5] == 3'h0 && ctl[1:0] == 2'h2 &&
        (result_value > hi || result_value < lo) |-> ##2 !int_n;
    endproperty
    a_lim: assert property (p_lim) else $error("no limit irq");
endmodule // prox_chk
bind proximity_threshold_interrupt prox_chk chk (
    .clk          (clk),
    .rst_n        (rst_n),
    .reg_addr     (reg_addr),
    .reg_wr       (reg_wr),
    .reg_wdata    (reg_wdata),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .result_ready (result_ready),
    .result_value (result_value),
    .int_n        (int_n)
);
`default_nettype wire

// *** verification/proximity_threshold_interrupt_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// self-checking run
// ------------------------------------
module proximity_threshold_interrupt_bench;
    logic        clk = 1'b0, rst_n = 1'b0, result_ready = 1'b0, reg_wr, reg_rd, int_n;
    logic [15:0] result_value = 16'h0000, lo, hi, v;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    int          err_total = 0, n_tests = 0;
    prox_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    proximity_threshold_interrupt uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .result_ready(result_ready), .result_value(result_value), .int_n(int_n));
    initial forever #5 clk = ~clk;
    function automatic int cnt(input int k);
        return (k == 7) ? 128 : (1 << k);
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk("register read", d, e);
    endtask
    task automatic send(input logic [15:0] x);
        @(negedge clk);
        result_value = x;
        result_ready = 1'b1;
        @(negedge clk);
        result_ready = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        final_report;
    end
    initial begin
        v = $urandom(32'h1ed7a68a);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk("int_n", int_n, 16'h1);
        rdc(8'h89, 8'h00);
        lo = 16'($urandom_range(16'h7000, 16'h1000));
        hi = lo + 16'h0100;
        for (int i = 0; i < 4; i++) host.wr(8'h8a + i, 8'({lo, hi} >> (24 - 8 * i)));
        for (int i = 0; i < 4; i++) rdc(8'h8a + i, 8'({lo, hi} >> (24 - 8 * i)));
        v = 16'($urandom);
        send(v);
        rdc(8'h80, 8'h20);
        host.wr(8'h87, ~v[15:8]);
        host.wr(8'h88, ~v[7:0]);
        rdc(8'h87, v[15:8]);
        rdc(8'h80, 8'h00);
        rdc(8'h88, v[7:0]);
        rdc(8'h50, 8'h00);
        host.wr(8'h89, 8'hff);
        rdc(8'h89, 8'heb);
        send(hi + 16'h1);
        rdc(8'h8e, 8'h04);
        chk("int_n", int_n, 16'h0);
        host.wr(8'h8e, 8'h04);
        chk("int_n", int_n, 16'h1);
        host.wr(8'h89, 8'h02);
        // equal values sit inside the limits, one step out must flag
        for (int i = 0; i < 4; i++) begin
            send(i[1] ? (i[0] ? lo - 16'h1 : hi + 16'h1) : (i[0] ? lo : hi));
            rdc(8'h8e, {6'h0, i[1] & i[0], i[1] & ~i[0]});
            host.wr(8'h8e, 8'h07);
        end
        for (int k = 0; k < 8; k++) begin
            host.wr(8'h89, {k[2:0], 5'h02});
            send(hi);
            repeat (cnt(k) - 1) send(hi + 16'h1 + 16'($urandom_range(255)));
            send(lo);
            repeat (cnt(k) - 1) send(hi + 16'h1 + 16'($urandom_range(255)));
            rdc(8'h8e, 8'h00);
            send(hi + 16'h1 + 16'($urandom_range(255)));
            rdc(8'h8e, 8'h01);
            host.wr(8'h8e, 8'h01);
        end
        final_report;
    end
endmodule // proximity_threshold_interrupt_bench
`default_nettype wire
